// ===== hdl/fph_consts.vh
// fph_consts.vh: constants for the float result forwarding and hazard block.
// assumes it is included by bare name from the design files.
`ifndef FPH_CONSTS_VH
`define FPH_CONSTS_VH
// widths
`define FPH_DATA_W 32
`define FPH_REG_AW 3
`define FPH_NUM_REGS 8
// arithmetic op codes
`define FPH_OP_W 3
`define FPH_OP_NONE 3'h0
`define FPH_OP_MUL 3'h1
`define FPH_OP_ADD 3'h2
`define FPH_OP_SUB 3'h3
`define FPH_OP_MAC 3'h4
`define FPH_OP_LOAD 3'h5
// move destination kinds
`define FPH_DST_W 2
`define FPH_DST_FLOAT 2'h0
`define FPH_DST_CPU 2'h1
// coprocessor stage count: read one, read two, execute one to three
`define FPH_STAGES 5
`define FPH_ST_R1 0
`define FPH_ST_R2 1
`define FPH_ST_E1 2
`define FPH_ST_E2 3
`define FPH_ST_E3 4
`define FPH_ZERO32 32'h00000000
`endif

// ===== hdl/fph_stage.v
// fph_stage.v: one coprocessor pipeline slot holding an instruction.
// assumes a synchronous active high reset and a shared hold signal.
`timescale 1ns/1ps
`include "fph_consts.vh"
module fph_stage
(
    input wire clk,
    input wire rst,
    input wire hold,
    input wire in_valid,
    input wire [`FPH_OP_W-1:0] in_op,
    input wire [`FPH_REG_AW-1:0] in_dst,
    input wire [`FPH_REG_AW-1:0] in_src_a,
    input wire [`FPH_REG_AW-1:0] in_src_b,
    input wire in_move,
    input wire [`FPH_DST_W-1:0] in_move_kind,
    input wire [`FPH_DATA_W-1:0] in_opnd_a,
    input wire [`FPH_DATA_W-1:0] in_opnd_b,
    output reg out_valid,
    output reg [`FPH_OP_W-1:0] out_op,
    output reg [`FPH_REG_AW-1:0] out_dst,
    output reg [`FPH_REG_AW-1:0] out_src_a,
    output reg [`FPH_REG_AW-1:0] out_src_b,
    output reg out_move,
    output reg [`FPH_DST_W-1:0] out_move_kind,
    output reg [`FPH_DATA_W-1:0] out_opnd_a,
    output reg [`FPH_DATA_W-1:0] out_opnd_b
);
    // slot register: loads when the pipe advances, holds through a stall
    always @(posedge clk)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_op <= `FPH_OP_NONE;
            out_dst <= {`FPH_REG_AW{1'b0}};
            out_src_a <= {`FPH_REG_AW{1'b0}};
            out_src_b <= {`FPH_REG_AW{1'b0}};
            out_move <= 1'b0;
            out_move_kind <= `FPH_DST_FLOAT;
            out_opnd_a <= `FPH_ZERO32;
            out_opnd_b <= `FPH_ZERO32;
        end
        else if (!hold)
        begin
            out_valid <= in_valid;
            out_op <= in_op;
            out_dst <= in_dst;
            out_src_a <= in_src_a;
            out_src_b <= in_src_b;
            out_move <= in_move;
            out_move_kind <= in_move_kind;
            out_opnd_a <= in_opnd_a;
            out_opnd_b <= in_opnd_b;
        end
    end
endmodule

// ===== hdl/fph_pipe.v
// fph_pipe.v: coprocessor pipeline with result forwarding and move capture.
// assumes the host issues one instruction per cycle when issue_ready is high
// and takes move results from move_valid/move_data.
`timescale 1ns/1ps
`include "fph_consts.vh"
module fph_pipe
(
    input wire clk,
    input wire rst,
    input wire stall,
    input wire issue_valid,
    input wire [`FPH_OP_W-1:0] issue_op,
    input wire [`FPH_REG_AW-1:0] issue_dst,
    input wire [`FPH_REG_AW-1:0] issue_src_a,
    input wire [`FPH_REG_AW-1:0] issue_src_b,
    input wire issue_move,
    input wire [`FPH_DST_W-1:0] issue_move_kind,
    input wire [`FPH_DATA_W-1:0] issue_imm,
    output wire issue_ready,
    output reg move_valid,
    output reg [`FPH_DATA_W-1:0] move_data,
    output reg fwd_used
);
    // coprocessor register file
    reg [`FPH_DATA_W-1:0] regs [0:`FPH_NUM_REGS-1];
    // per-stage fields, index 0 is read one
    wire [`FPH_STAGES-1:0] st_valid;
    wire [`FPH_OP_W*`FPH_STAGES-1:0] st_op;
    wire [`FPH_REG_AW*`FPH_STAGES-1:0] st_dst;
    wire [`FPH_REG_AW*`FPH_STAGES-1:0] st_src_a;
    wire [`FPH_REG_AW*`FPH_STAGES-1:0] st_src_b;
    wire [`FPH_STAGES-1:0] st_move;
    wire [`FPH_DST_W*`FPH_STAGES-1:0] st_kind;
    wire [`FPH_DATA_W*`FPH_STAGES-1:0] st_a;
    wire [`FPH_DATA_W*`FPH_STAGES-1:0] st_b;
    // operands captured entering read two (register, write-through or forward)
    wire [`FPH_DATA_W-1:0] next_r2_opnd_a;
    wire [`FPH_DATA_W-1:0] next_r2_opnd_b;
    // finished producer result, kept while the producer waits in e3
    reg [`FPH_DATA_W-1:0] e3_hold;
    // result computed from the second execute phase operands, as the producer enters e3
    reg [`FPH_DATA_W-1:0] e3_result;
    wire e3_valid;
    wire e3_arith;
    wire [`FPH_REG_AW-1:0] e3_dst;
    wire [`FPH_REG_AW-1:0] r1_src_a;
    wire [`FPH_REG_AW-1:0] r1_src_b;
    wire e2_arith;
    wire [`FPH_REG_AW-1:0] e2_dst;
    // hazard pairing: any instruction about to enter read two while an e2 producer enters e3
    wire fwd_hit_a;
    wire fwd_hit_b;
    wire [`FPH_DATA_W-1:0] mul_ab;
    // write-through: producer leaving e3 as the reader enters read two
    wire wt_hit_a;
    wire wt_hit_b;
    // a load carries its immediate into read two instead of a register
    wire r1_load;
    // a move toward a cpu register sitting in read two
    wire move_out;
    // slot inputs: slot 0 from issue, slot 1 from the capture, the rest shift
    wire [`FPH_STAGES-1:0] sh_valid;
    wire [`FPH_OP_W*`FPH_STAGES-1:0] sh_op;
    wire [`FPH_REG_AW*`FPH_STAGES-1:0] sh_dst;
    wire [`FPH_REG_AW*`FPH_STAGES-1:0] sh_src_a;
    wire [`FPH_REG_AW*`FPH_STAGES-1:0] sh_src_b;
    wire [`FPH_STAGES-1:0] sh_move;
    wire [`FPH_DST_W*`FPH_STAGES-1:0] sh_kind;
    wire [`FPH_DATA_W*`FPH_STAGES-1:0] sh_a;
    wire [`FPH_DATA_W*`FPH_STAGES-1:0] sh_b;
    integer i;

    // whole pipe freezes on a stall, issue waits too
    assign issue_ready = !stall;

    assign e3_valid = st_valid[`FPH_ST_E3];
    assign e3_dst = st_dst[`FPH_ST_E3*`FPH_REG_AW +: `FPH_REG_AW];
    assign e3_arith = e3_valid && (st_op[`FPH_ST_E3*`FPH_OP_W +: `FPH_OP_W] != `FPH_OP_NONE);
    assign e2_arith = st_valid[`FPH_ST_E2] &&
        (st_op[`FPH_ST_E2*`FPH_OP_W +: `FPH_OP_W] != `FPH_OP_NONE);
    assign e2_dst = st_dst[`FPH_ST_E2*`FPH_REG_AW +: `FPH_REG_AW];
    assign r1_src_a = st_src_a[`FPH_ST_R1*`FPH_REG_AW +: `FPH_REG_AW];
    assign r1_src_b = st_src_b[`FPH_ST_R1*`FPH_REG_AW +: `FPH_REG_AW];
    // the instruction entering read two now sits in read one; the producer
    // entering e3 at that edge now sits in e2, so forwarding uses its value
    assign fwd_hit_a = st_valid[`FPH_ST_R1] && e2_arith && (e2_dst == r1_src_a);
    assign fwd_hit_b = st_valid[`FPH_ST_R1] && e2_arith && (e2_dst == r1_src_b);
    // without write-through the reader would see the old register value,
    // since the write lands at the very edge where the reader samples
    assign wt_hit_a = st_valid[`FPH_ST_R1] && e3_arith && (e3_dst == r1_src_a);
    assign wt_hit_b = st_valid[`FPH_ST_R1] && e3_arith && (e3_dst == r1_src_b);
    assign r1_load = (st_op[`FPH_ST_R1*`FPH_OP_W +: `FPH_OP_W] == `FPH_OP_LOAD);
    // the newest value wins: e2 forward, then e3 write-through, then the file
    assign next_r2_opnd_a = r1_load ? st_a[`FPH_ST_R1*`FPH_DATA_W +: `FPH_DATA_W] :
        fwd_hit_a ? e3_result : wt_hit_a ? e3_hold : regs[r1_src_a];
    assign next_r2_opnd_b = fwd_hit_b ? e3_result :
        wt_hit_b ? e3_hold : regs[r1_src_b];

    // shift inputs; read two takes the capture above, never a re-sample
    assign sh_valid = {st_valid[`FPH_STAGES-2:0], issue_valid && !stall};
    assign sh_op = {st_op[`FPH_OP_W*(`FPH_STAGES-1)-1:0], issue_op};
    assign sh_dst = {st_dst[`FPH_REG_AW*(`FPH_STAGES-1)-1:0], issue_dst};
    assign sh_src_a = {st_src_a[`FPH_REG_AW*(`FPH_STAGES-1)-1:0], issue_src_a};
    assign sh_src_b = {st_src_b[`FPH_REG_AW*(`FPH_STAGES-1)-1:0], issue_src_b};
    assign sh_move = {st_move[`FPH_STAGES-2:0], issue_move};
    assign sh_kind = {st_kind[`FPH_DST_W*(`FPH_STAGES-1)-1:0], issue_move_kind};
    assign sh_a = {st_a[`FPH_DATA_W*(`FPH_STAGES-1)-1:`FPH_DATA_W*`FPH_ST_R2],
        next_r2_opnd_a, issue_imm};
    assign sh_b = {st_b[`FPH_DATA_W*(`FPH_STAGES-1)-1:`FPH_DATA_W*`FPH_ST_R2],
        next_r2_opnd_b, `FPH_ZERO32};
    // only moves toward cpu registers produce a result outside
    assign move_out = st_valid[`FPH_ST_R2] && st_move[`FPH_ST_R2] &&
        (st_kind[`FPH_ST_R2*`FPH_DST_W +: `FPH_DST_W] == `FPH_DST_CPU);

    assign mul_ab = st_a[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W] *
        st_b[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W];

    // slot chain in stage order read one, read two, execute one to three
    genvar g;
    generate
        for (g = 0; g < `FPH_STAGES; g = g + 1)
        begin : gen_slot
            fph_stage u_slot
            (
                .clk(clk),
                .rst(rst),
                .hold(stall),
                .in_valid(sh_valid[g]),
                .in_op(sh_op[g*`FPH_OP_W +: `FPH_OP_W]),
                .in_dst(sh_dst[g*`FPH_REG_AW +: `FPH_REG_AW]),
                .in_src_a(sh_src_a[g*`FPH_REG_AW +: `FPH_REG_AW]),
                .in_src_b(sh_src_b[g*`FPH_REG_AW +: `FPH_REG_AW]),
                .in_move(sh_move[g]),
                .in_move_kind(sh_kind[g*`FPH_DST_W +: `FPH_DST_W]),
                .in_opnd_a(sh_a[g*`FPH_DATA_W +: `FPH_DATA_W]),
                .in_opnd_b(sh_b[g*`FPH_DATA_W +: `FPH_DATA_W]),
                .out_valid(st_valid[g]),
                .out_op(st_op[g*`FPH_OP_W +: `FPH_OP_W]),
                .out_dst(st_dst[g*`FPH_REG_AW +: `FPH_REG_AW]),
                .out_src_a(st_src_a[g*`FPH_REG_AW +: `FPH_REG_AW]),
                .out_src_b(st_src_b[g*`FPH_REG_AW +: `FPH_REG_AW]),
                .out_move(st_move[g]),
                .out_move_kind(st_kind[g*`FPH_DST_W +: `FPH_DST_W]),
                .out_opnd_a(st_a[g*`FPH_DATA_W +: `FPH_DATA_W]),
                .out_opnd_b(st_b[g*`FPH_DATA_W +: `FPH_DATA_W])
            );
        end
    endgenerate

    // the producer's result as it stands entering e3 (from e2 operands)
    always @*
    begin
        case (st_op[`FPH_ST_E2*`FPH_OP_W +: `FPH_OP_W])
            `FPH_OP_MUL: e3_result = mul_ab;
            `FPH_OP_ADD: e3_result = st_a[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W] +
                st_b[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W];
            `FPH_OP_SUB: e3_result = st_a[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W] -
                st_b[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W];
            `FPH_OP_MAC: e3_result = mul_ab + regs[e2_dst];
            `FPH_OP_LOAD: e3_result = st_a[`FPH_ST_E2*`FPH_DATA_W +: `FPH_DATA_W];
            default: e3_result = `FPH_ZERO32;
        endcase
    end

    // producer result and forwarding flag; both freeze through a stall, so
    // the forward already taken at read-two entry survives an e3 stall
    always @(posedge clk)
    begin
        if (rst)
        begin
            e3_hold <= `FPH_ZERO32;
            fwd_used <= 1'b0;
        end
        else if (!stall)
        begin
            // the result as the producer enters e3
            e3_hold <= e3_result;
            // flag follows non-load captures only, bubbles and loads leave it alone
            if (st_valid[`FPH_ST_R1] && !r1_load)
            begin
                fwd_used <= fwd_hit_a || fwd_hit_b;
            end
        end
        // a stall leaves the held operands untouched: no re-sample
    end

    // register write as producer leaves e3, so a later reader sees it
    always @(posedge clk)
    begin
        if (rst)
        begin
            for (i = 0; i < `FPH_NUM_REGS; i = i + 1)
            begin
                regs[i] <= `FPH_ZERO32;
            end
        end
        else if (!stall && e3_arith)
        begin
            regs[e3_dst] <= e3_hold;
        end
    end

    // move result: only moves toward cpu registers leave the coprocessor
    always @(posedge clk)
    begin
        if (rst)
        begin
            move_valid <= 1'b0;
            move_data <= `FPH_ZERO32;
        end
        else
        begin
            move_valid <= !stall && move_out;
            // data changes only with a pulse; float-only moves leave it
            if (!stall && move_out)
            begin
                move_data <= st_a[`FPH_ST_R2*`FPH_DATA_W +: `FPH_DATA_W];
            end
        end
    end
endmodule

// ===== sim/fph_pipe_sva.sv
// fph_pipe_sva.sv: port-level checks of the result forwarding pipeline.
// assumes the design constants header and the bind at the foot.
`timescale 1ns/1ps
`include "fph_consts.vh"
module fph_pipe_sva
(
    input wire clk,
    input wire rst,
    input wire stall,
    input wire issue_valid,
    input wire [`FPH_OP_W-1:0] issue_op,
    input wire [`FPH_REG_AW-1:0] issue_dst,
    input wire [`FPH_REG_AW-1:0] issue_src_a,
    input wire issue_move,
    input wire [`FPH_DST_W-1:0] issue_move_kind,
    input wire issue_ready,
    input wire move_valid,
    input wire [`FPH_DATA_W-1:0] move_data,
    input wire fwd_used
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // arithmetic producer writing r3
    sequence prod_s;
        issue_valid && !stall && !issue_move && issue_dst == 3'h3
            && issue_op >= `FPH_OP_MUL && issue_op <= `FPH_OP_MAC;
    endsequence
    // cpu move reading r3
    sequence mov_s;
        issue_valid && !stall && issue_move && issue_move_kind == `FPH_DST_CPU && issue_src_a == 3'h3;
    endsequence
    ready_track_a: assert property (issue_ready == !stall)
        else $error("issue_ready not the inverse of stall");
    move_lat_a: assert property (issue_valid && !stall && issue_move
        && issue_move_kind == `FPH_DST_CPU ##1 (!stall)[*2] |=> move_valid)
        else $error("move result late");
    quiet_out_a: assert property ((!stall && !(issue_valid && issue_move))[*4] |=> !move_valid)
        else $error("move result without a move");
    stall_hold_a: assert property (stall |=> $stable(move_data) && $stable(fwd_used))
        else $error("outputs moved during stall");
    data_cause_a: assert property (!$stable(move_data) |-> move_valid)
        else $error("move data changed without a move");
    reset_clear_a: assert property ($fell(rst) |-> !move_valid && move_data == 32'h00000000 && !fwd_used)
        else $error("outputs not cleared by reset");
    fwd_near_a: assert property (prod_s ##1 (!issue_valid && !stall)[*2]
        ##1 mov_s ##1 !stall |=> fwd_used)
        else $error("no forwarding at third execute phase");
    fwd_far_a: assert property (prod_s ##1 (!issue_valid && !stall)[*3]
        ##1 mov_s ##1 !stall |=> !fwd_used)
        else $error("forwarding used after result written");
    cover property (move_valid && fwd_used);
    cover property (stall ##1 stall);
    cover property (prod_s ##1 (!issue_valid)[*3] ##1 mov_s);
endmodule
bind fph_pipe fph_pipe_sva u_sva (.clk(clk), .rst(rst), .stall(stall), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_dst(issue_dst), .issue_src_a(issue_src_a), .issue_move(issue_move),
    .issue_move_kind(issue_move_kind), .issue_ready(issue_ready), .move_valid(move_valid),
    .move_data(move_data), .fwd_used(fwd_used));

// ===== sim/fph_host.sv
// fph_host.sv: behavioural host issuer for the pipeline's issue side.
// assumes tasks are called just after a rising edge of clk.
`timescale 1ns/1ps
`include "fph_consts.vh"
module fph_host
(
    input wire clk,
    input wire issue_ready,
    output reg issue_valid,
    output reg [`FPH_OP_W-1:0] issue_op,
    output reg [`FPH_REG_AW-1:0] issue_dst,
    output reg [`FPH_REG_AW-1:0] issue_src_a,
    output reg [`FPH_REG_AW-1:0] issue_src_b,
    output reg issue_move,
    output reg [`FPH_DST_W-1:0] issue_move_kind,
    output reg [`FPH_DATA_W-1:0] issue_imm
);
    // slots from an arithmetic producer to a dependent cpu move
    localparam integer SAFE_GAP = 4;
    initial {issue_valid, issue_op, issue_dst, issue_src_a, issue_src_b, issue_move,
        issue_move_kind, issue_imm} = '0;
    // hold one instruction until an unstalled edge takes it
    task send(input [2:0] op, input [2:0] dst, input [2:0] sa, input mv, input [31:0] imm);
        begin
            issue_valid <= 1'b1;
            issue_op <= op;
            issue_dst <= dst;
            issue_src_a <= sa;
            issue_src_b <= 3'h2;
            issue_move <= mv;
            issue_move_kind <= `FPH_DST_CPU;
            issue_imm <= imm;
            @(posedge clk);
            while (!issue_ready)
                @(posedge clk);
        end
    endtask
    // one move of the given destination kind reading register sa
    task send_move(input [1:0] kind, input [2:0] sa);
        begin
            issue_valid <= 1'b1;
            issue_op <= `FPH_OP_NONE;
            issue_dst <= 3'h0;
            issue_src_a <= sa;
            issue_src_b <= 3'h2;
            issue_move <= 1'b1;
            issue_move_kind <= kind;
            issue_imm <= 32'h00000000;
            @(posedge clk);
            while (!issue_ready)
                @(posedge clk);
        end
    endtask
    // empty slots; the immediate and source b fields show inverted values
    task idle(input integer n);
        begin
            issue_valid <= 1'b0;
            issue_imm <= ~issue_imm;
            issue_src_b <= ~issue_src_b;
            repeat (n) @(posedge clk);
        end
    endtask
endmodule

// ===== sim/fph_pipe_tb_top.sv
// fph_pipe_tb_top.sv: self-checking bench for the forwarding pipeline.
// assumes fph_host drives the issue side and the checker is bound in.
`timescale 1ns/1ps
`include "fph_consts.vh"
`define TB_CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin failures = failures + 1; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module fph_pipe_tb_top;
    reg clk, rst, stall; // bench driven
    wire iv, im, ir, mvv, fwd; // handshake and flags
    wire [2:0] iop, idst, isa, isb; // instruction fields
    wire [1:0] ik; // move kind
    wire [31:0] imm, mdata; // load value, move result
    integer failures, n_compared;
    fph_host u_host (.clk(clk), .issue_ready(ir), .issue_valid(iv), .issue_op(iop),
        .issue_dst(idst), .issue_src_a(isa), .issue_src_b(isb), .issue_move(im),
        .issue_move_kind(ik), .issue_imm(imm));
    fph_pipe u_dut (.clk(clk), .rst(rst), .stall(stall), .issue_valid(iv), .issue_op(iop),
        .issue_dst(idst), .issue_src_a(isa), .issue_src_b(isb), .issue_move(im),
        .issue_move_kind(ik), .issue_imm(imm), .issue_ready(ir), .move_valid(mvv),
        .move_data(mdata), .fwd_used(fwd));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // r1=7 r2=6 r3=5, op into r3, move of r3 after gap slots, optional e3 stall
    task run(input [2:0] op, input integer gap, input stl, input [31:0] exp, input fw);
        integer n;
        begin
            u_host.send(`FPH_OP_LOAD, 3'h1, 3'h0, 1'b0, 32'h00000007);
            u_host.send(`FPH_OP_LOAD, 3'h2, 3'h0, 1'b0, 32'h00000006);
            u_host.send(`FPH_OP_LOAD, 3'h3, 3'h0, 1'b0, 32'h00000005);
            u_host.idle(4);
            u_host.send(op, 3'h3, 3'h1, 1'b0, 32'h00000000);
            u_host.idle(gap - 1);
            u_host.send(`FPH_OP_NONE, 3'h0, 3'h3, 1'b1, 32'h00000000);
            u_host.idle(0);
            if (stl)
            begin
                @(posedge clk);
                stall <= 1'b1;
                repeat (2) @(posedge clk);
                stall <= 1'b0;
            end
            n = 0;
            while (mvv !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                n = n + 1;
            end
            `TB_CHK(mvv, 1'b1)
            `TB_CHK(mdata, exp)
            `TB_CHK(fwd, fw)
        end
    endtask
    task t_reset_vals;
        begin
            @(posedge clk);
            `TB_CHK({mvv, fwd, mdata}, 34'h000000000)
        end
    endtask
    task t_each_op;
        begin
            run(`FPH_OP_MUL, 3, 1'b0, 32'h0000002A, 1'b1);
            run(`FPH_OP_ADD, 3, 1'b0, 32'h0000000D, 1'b1);
            run(`FPH_OP_SUB, 3, 1'b0, 32'h00000001, 1'b1);
            run(`FPH_OP_MAC, 3, 1'b0, 32'h0000002F, 1'b1);
        end
    endtask
    task t_safe_gap;
        run(`FPH_OP_MUL, u_host.SAFE_GAP, 1'b0, 32'h0000002A, 1'b0);
    endtask
    task t_stall_e3;
        run(`FPH_OP_MUL, 3, 1'b1, 32'h0000002A, 1'b1);
    endtask
    // float-destination move gives no result; a cpu move of the same register does
    task t_float_move;
        integer n;
        begin
            u_host.send_move(`FPH_DST_FLOAT, 3'h1);
            u_host.idle(0);
            n = 0;
            repeat (6)
            begin
                @(posedge clk);
                if (mvv === 1'b1)
                    n = n + 1;
            end
            `TB_CHK(n, 32'h00000000)
            `TB_CHK(mdata, 32'h0000002A)
            u_host.send_move(`FPH_DST_CPU, 3'h1);
            u_host.idle(0);
            repeat (3) @(posedge clk);
            `TB_CHK({mvv, mdata}, 33'h100000007)
        end
    endtask
    task summarize;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        failures = 0;
        n_compared = 0;
        rst = 1'b1;
        stall = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals;
        t_each_op;
        t_safe_gap;
        t_stall_e3;
        t_float_move;
        summarize;
    end
    // watchdog well beyond the hundred or so cycles the scenarios need
    initial
    begin
        repeat (5000) @(posedge clk);
        failures = failures + 1;
        summarize;
    end
endmodule
